// ---- atc_pkg.sv ----
/*
 * atc_pkg: register offsets, bit positions, reset values and timing constants
 * for the auxiliary timer with capture, autoreload, baud and clock-out modes.
 * assumes an 8-bit register port addressed by the printed byte offsets.
 */
package atc_pkg;

    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;

    // register offsets
    localparam logic [7:0]  OFS_CONTROL     = 8'hC8;
    localparam logic [7:0]  OFS_MODE        = 8'hC9;
    localparam logic [7:0]  OFS_CAP_LOW     = 8'hCA;
    localparam logic [7:0]  OFS_CAP_HIGH    = 8'hCB;
    localparam logic [7:0]  OFS_COUNT_LOW   = 8'hCC;
    localparam logic [7:0]  OFS_COUNT_HIGH  = 8'hCD;

    // control register bit positions
    localparam int          BIT_OVF         = 7;
    localparam int          BIT_EXT_FLAG    = 6;
    localparam int          BIT_RCLK_SEL    = 5;
    localparam int          BIT_TRANSMIT_CLOCK_SELECT_SEL    = 4;
    localparam int          BIT_EXT_EN      = 3;
    localparam int          BIT_RUN         = 2;
    localparam int          BIT_CT_SEL      = 1;
    localparam int          BIT_CAP_SEL     = 0;

    // mode register bit positions
    localparam int          BIT_CLK_OE      = 1;
    localparam int          BIT_DOWN_EN     = 0;
    localparam logic [7:0]  MODE_RSVD_MASK  = 8'hFC;

    // reset values and count top
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    localparam logic [15:0] RST_COUNT       = 16'h0000;
    localparam logic [15:0] COUNT_TOP       = 16'hFFFF;

    // timing
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          BAUD_DIV_CLKS   = 2;

endpackage : atc_pkg

// ---- atc_timer.sv ----
/*
 * atc_timer: 16-bit auxiliary timer/counter with capture, 16-bit autoreload
 * (optionally up/down), serial baud generation and clock output on the counter pin.
 * assumes a single 100 MHz clock, synchronous active-low reset, a byte-wide
 * register port with one-cycle strobes, and asynchronous pin inputs.
 */
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
module atc_timer
    import atc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              timer_tick,
    input  wire logic              counter_pin_in,
    output logic                   counter_pin_out,
    output logic                   counter_pin_oe,
    input  wire logic              trigger_pin,
    output logic                   timer_irq,
    output logic                   rx_baud_from_timer,
    output logic                   tx_baud_from_timer,
    output logic                   baud_overflow
);

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  control;
    logic        clock_output_enable;
    logic        down_count_enable;
    logic [15:0] reload;
    logic [15:0] count;
    logic        sw_ext_set;

    logic overflow_flag;
    logic external_flag;
    logic transmit_clock_select;
    logic receive_clock_select;
    logic external_enable;
    logic run_bit;
    logic counter_timer_select;
    logic capture_reload_select;

    assign overflow_flag         = control[BIT_OVF];
    assign external_flag         = control[BIT_EXT_FLAG];
    assign receive_clock_select  = control[BIT_RCLK_SEL];
    assign transmit_clock_select = control[BIT_TRANSMIT_CLOCK_SELECT_SEL];
    assign external_enable       = control[BIT_EXT_EN];
    assign run_bit               = control[BIT_RUN];
    assign counter_timer_select  = control[BIT_CT_SEL];
    assign capture_reload_select = control[BIT_CAP_SEL];

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and edge detection
    logic [1:0] trig_sync;
    logic [1:0] cnt_sync;
    logic       trig_prev;
    logic       cnt_prev;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trig_sync <= 2'h3;
            cnt_sync  <= 2'h3;
            trig_prev <= 1'b1;
            cnt_prev  <= 1'b1;
        end else begin
            trig_sync <= {trig_sync[0], trigger_pin};
            cnt_sync  <= {cnt_sync[0], counter_pin_in};
            trig_prev <= trig_sync[1];
            cnt_prev  <= cnt_sync[1];
        end
    end

    logic trig_level;
    logic trig_fall;
    logic cnt_fall;
    assign trig_level = trig_sync[1];
    assign trig_fall  = trig_prev & ~trig_level;
    assign cnt_fall   = cnt_prev & ~cnt_sync[1];

    ////////////////////////////////////////////////////////////////////////////
    // mode decode
    logic baud_mode;
    logic clkout_mode;
    logic fast_mode;
    logic updown_mode;
    logic trig_event;

    assign baud_mode   = receive_clock_select | transmit_clock_select;
    assign clkout_mode = clock_output_enable & ~counter_timer_select;
    assign fast_mode   = baud_mode | clkout_mode;
    assign updown_mode = ~capture_reload_select & down_count_enable & ~baud_mode;
    // baud generation takes the trigger pin away from capture/reload
    assign trig_event  = trig_fall & external_enable & ~baud_mode;

    ////////////////////////////////////////////////////////////////////////////
    // count advance
    logic half_clk;
    logic advance;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            half_clk <= 1'b0;
        end else begin
            half_clk <= ~half_clk;
        end
    end

    always_comb begin
        if (!run_bit) begin
            advance = 1'b0;
        end else if (fast_mode) begin
            advance = half_clk;
        end else if (counter_timer_select) begin
            advance = cnt_fall;
        end else begin
            advance = timer_tick;
        end
    end

    logic count_down;
    logic wrap_up;
    logic wrap_down;
    logic rollover;
    assign count_down = updown_mode & ~trig_level;
    assign wrap_up    = advance & ~count_down & (count == COUNT_TOP);
    assign wrap_down  = advance & count_down & (count == reload);
    assign rollover   = wrap_up | wrap_down;

    logic reload_on_wrap;
    assign reload_on_wrap = ~capture_reload_select | baud_mode;

    logic [15:0] next_count;
    always_comb begin
        next_count = count;
        if (trig_event & ~capture_reload_select) begin
            next_count = reload;
        end else if (wrap_down) begin
            next_count = COUNT_TOP;
        end else if (wrap_up & reload_on_wrap) begin
            next_count = reload;
        end else if (advance & count_down) begin
            next_count = count - 16'h0001;
        end else if (advance) begin
            next_count = count + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes
    logic wr_ctrl;
    assign wr_ctrl = reg_write & (reg_addr == OFS_CONTROL);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= RST_COUNT;
        end else if (reg_write & (reg_addr == OFS_COUNT_LOW)) begin
            count <= {next_count[15:8], reg_wdata};
        end else if (reg_write & (reg_addr == OFS_COUNT_HIGH)) begin
            count <= {reg_wdata, next_count[7:0]};
        end else begin
            count <= next_count;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reload <= {RST_BYTE, RST_BYTE};
        end else if (trig_event & capture_reload_select) begin
            reload <= count;
        end else if (reg_write & (reg_addr == OFS_CAP_LOW)) begin
            reload[7:0] <= reg_wdata;
        end else if (reg_write & (reg_addr == OFS_CAP_HIGH)) begin
            reload[15:8] <= reg_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clock_output_enable <= 1'b0;
            down_count_enable   <= 1'b0;
        end else if (reg_write & (reg_addr == OFS_MODE)) begin
            clock_output_enable <= reg_wdata[BIT_CLK_OE];
            down_count_enable   <= reg_wdata[BIT_DOWN_EN];
        end
    end

    // hardware set wins over a software clear in the same cycle
    logic set_ovf;
    logic set_ext;
    logic tog_ext;
    assign set_ovf = rollover & ~baud_mode;
    assign set_ext = trig_fall & external_enable & ~baud_mode
                   & (capture_reload_select | ~down_count_enable);
    assign tog_ext = rollover & updown_mode;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            control <= RST_BYTE;
        end else begin
            if (wr_ctrl) begin
                control <= reg_wdata;
            end
            if (set_ovf) begin
                control[BIT_OVF] <= 1'b1;
            end
            if (set_ext) begin
                control[BIT_EXT_FLAG] <= 1'b1;
            end else if (tog_ext) begin
                control[BIT_EXT_FLAG] <= ~external_flag;
            end
        end
    end

    // a software write of one to the external flag also requests service
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sw_ext_set <= 1'b0;
        end else begin
            sw_ext_set <= wr_ctrl & reg_wdata[BIT_EXT_FLAG];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= RST_BYTE;
        end else if (reg_read) begin
            unique case (reg_addr)
                OFS_CONTROL:    reg_rdata <= control;
                OFS_MODE:       reg_rdata <= MODE_RSVD_MASK
                                           | {6'h00, clock_output_enable,
                                              down_count_enable};
                OFS_CAP_LOW:    reg_rdata <= reload[7:0];
                OFS_CAP_HIGH:   reg_rdata <= reload[15:8];
                OFS_COUNT_LOW:  reg_rdata <= count[7:0];
                OFS_COUNT_HIGH: reg_rdata <= count[15:8];
                default:        reg_rdata <= RST_BYTE;
            endcase
        end else begin
            reg_rdata <= RST_BYTE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    // the 17th-bit toggle mode keeps the external flag off the interrupt line
    logic irq_ovf;
    logic irq_ext;
    logic clk_out;
    logic baud_pulse;
    assign irq_ovf = overflow_flag & ~clkout_mode;
    assign irq_ext = (external_flag & ~updown_mode) | sw_ext_set;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timer_irq  <= 1'b0;
            clk_out    <= 1'b0;
            baud_pulse <= 1'b0;
        end else begin
            timer_irq  <= irq_ovf | irq_ext;
            baud_pulse <= rollover & baud_mode;
            if (rollover & clkout_mode) begin
                clk_out <= ~clk_out;
            end
        end
    end

    assign counter_pin_out    = clk_out;
    assign counter_pin_oe     = clkout_mode;
    assign rx_baud_from_timer = receive_clock_select;
    assign tx_baud_from_timer = transmit_clock_select;
    assign baud_overflow      = baud_pulse;

endmodule : atc_timer

// ---- atc_timer_assertions.sv ----
/* atc_timer_checker: concurrent checks on the ports of atc_timer.
   assumes it is bound to atc_timer and sees only that module's ports. */
`timescale 1ns/10ps
module atc_timer_checker
    import atc_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_write,
    input wire logic              reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              counter_pin_oe,
    input wire logic              rx_baud_from_timer,
    input wire logic              tx_baud_from_timer,
    input wire logic              baud_overflow
);
    logic [1:0] mode_wr;
    logic       run_wr;
    // software alone writes these bits, so a shadow from the bus is exact
    always_ff @(posedge clk) begin
        if (!rst_n) mode_wr <= 2'h0;
        else if (reg_write && reg_addr == OFS_MODE) mode_wr <= reg_wdata[1:0];
    end
    always_ff @(posedge clk) begin
        if (!rst_n) run_wr <= 1'h0;
        else if (reg_write && reg_addr == OFS_CONTROL) run_wr <= reg_wdata[BIT_RUN];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    property p_rdata_idle;
        !$past(reg_read) |-> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
    property p_mode_read;
        reg_read && reg_addr == OFS_MODE |=> reg_rdata == {6'h3F, mode_wr};
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("mode register readback");
    property p_rx_sel;
        reg_write && reg_addr == OFS_CONTROL |=> rx_baud_from_timer == $past(reg_wdata[5]);
    endproperty
    a_rx_sel: assert property (p_rx_sel) else $error("receive baud select");
    property p_tx_sel;
        reg_write && reg_addr == OFS_CONTROL |=> tx_baud_from_timer == $past(reg_wdata[4]);
    endproperty
    a_tx_sel: assert property (p_tx_sel) else $error("transmit baud select");
    property p_baud_only;
        baud_overflow |-> $past(rx_baud_from_timer || tx_baud_from_timer);
    endproperty
    a_baud_only: assert property (p_baud_only) else $error("baud pulse outside baud mode");
    property p_baud_pulse;
        baud_overflow |=> !baud_overflow;
    endproperty
    a_baud_pulse: assert property (p_baud_pulse) else $error("baud rollovers too close");
    property p_oe_off;
        reg_write && reg_addr == OFS_MODE && !reg_wdata[BIT_CLK_OE] |=> !counter_pin_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("clock output still driven");
    property p_count_hold;
        reg_write && reg_addr == OFS_COUNT_LOW && !run_wr ##2 reg_read && reg_addr == OFS_COUNT_LOW
            |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("halted count changed");
endmodule : atc_timer_checker

bind atc_timer atc_timer_checker u_chk (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .counter_pin_oe(counter_pin_oe), .rx_baud_from_timer(rx_baud_from_timer),
    .tx_baud_from_timer(tx_baud_from_timer), .baud_overflow(baud_overflow)
);

// ---- atc_pins_model.sv ----
/* atc_pins_model: trigger and counter pins, and the serial baud consumer.
   assumes pull-ups on both pins, so a released pin reads high. */
`timescale 1ns/10ps
module atc_pins_model (
    input wire logic clk,
    input wire logic rx_baud_from_timer,
    input wire logic tx_baud_from_timer,
    input wire logic baud_overflow,
    output logic     trigger_pin,
    output logic     counter_drive
);
    int baud_cnt = 0;
    initial trigger_pin = 1'h1;
    initial counter_drive = 1'h1;
    always @(posedge clk) if (baud_overflow && (rx_baud_from_timer || tx_baud_from_timer)) baud_cnt++;
    // each level held at least 3 clocks so the two-flop sync never misses it
    task automatic pulse_trig;
        @(posedge clk) trigger_pin <= 1'h0;
        repeat (3) @(posedge clk);
        trigger_pin <= 1'h1;
        repeat (4) @(posedge clk);
    endtask : pulse_trig
    task automatic pulse_cnt;
        @(posedge clk) counter_drive <= 1'h0;
        repeat (3) @(posedge clk);
        counter_drive <= 1'h1;
        repeat (4) @(posedge clk);
    endtask : pulse_cnt
    task automatic set_trig(input logic v);
        @(posedge clk) trigger_pin <= v;
        repeat (4) @(posedge clk);
    endtask : set_trig
endmodule : atc_pins_model

// ---- atc_timer_tb_top.sv ----
/* atc_timer_tb_top: self-checking bench for atc_timer.
   assumes atc_pkg, the pins model and the bound checker are compiled first. */
`timescale 1ns/10ps
module atc_timer_tb_top import atc_pkg::*;;
    logic       clk = 1'h0, rst_n = 1'h0, reg_write = 1'h0, reg_read = 1'h0, timer_tick = 1'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic       pin_out, pin_oe, trigger_pin, counter_drive, irq, rx_sel, tx_sel, baud_ovf;
    int         num_errors = 0, total_checks = 0, n0;
    typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} atc_row_t;
    atc_row_t rows [16] = '{
        '{1'h0, 8'hC8, 8'h00, 8'h00}, '{1'h0, 8'hC9, 8'h00, 8'hFC}, '{1'h0, 8'hCA, 8'h00, 8'h00},
        '{1'h0, 8'hCB, 8'h00, 8'h00}, '{1'h0, 8'hCC, 8'h00, 8'h00}, '{1'h0, 8'hCD, 8'h00, 8'h00},
        '{1'h0, 8'hC7, 8'h00, 8'h00}, '{1'h1, 8'hCA, 8'hAB, 8'hAB}, '{1'h1, 8'hCB, 8'h5C, 8'h5C},
        '{1'h1, 8'hCC, 8'h12, 8'h12}, '{1'h1, 8'hCD, 8'h34, 8'h34}, '{1'h1, 8'hC9, 8'hFF, 8'hFF},
        '{1'h1, 8'hC9, 8'h00, 8'hFC}, '{1'h1, 8'hC8, 8'h09, 8'h09}, '{1'h1, 8'hC8, 8'h00, 8'h00},
        '{1'h1, 8'hC7, 8'h55, 8'h00}};
    atc_timer uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .timer_tick(timer_tick), .counter_pin_in(pin_oe ? pin_out : counter_drive),
        .counter_pin_out(pin_out), .counter_pin_oe(pin_oe), .trigger_pin(trigger_pin),
        .timer_irq(irq), .rx_baud_from_timer(rx_sel), .tx_baud_from_timer(tx_sel),
        .baud_overflow(baud_ovf));
    atc_pins_model pm (.clk(clk), .rx_baud_from_timer(rx_sel), .tx_baud_from_timer(tx_sel),
        .baud_overflow(baud_ovf), .trigger_pin(trigger_pin), .counter_drive(counter_drive));
    ////////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= w;
        reg_read <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'h0;
        reg_read <= 1'h0;
    endtask : bus
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'h0, a, 8'h00);
        @(negedge clk);
        chk($sformatf("register %h", a), e, reg_rdata);
    endtask : rd
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk) timer_tick <= 1'h1;
            @(posedge clk) timer_tick <= 1'h0;
        end
    endtask : tick
    task automatic stop_test;
        if (num_errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////////
    initial forever #5 clk = ~clk;
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        $display("[ERR] run length expected below 20000 cycles seen more");
        stop_test();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        foreach (rows[i]) begin
            if (rows[i].w) bus(1'h1, rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        // rollover from FFFF reloads the capture pair and sets the overflow flag
        bus(1'h1, 8'hCA, 8'h34); bus(1'h1, 8'hCB, 8'h12); bus(1'h1, 8'hCC, 8'hFE);
        bus(1'h1, 8'hCD, 8'hFF); bus(1'h1, 8'hC8, 8'h04); tick(2);
        rd(8'hCC, 8'h34); rd(8'hCD, 8'h12);
        rd(8'hC8, 8'h84);
        bus(1'h1, 8'hCC, 8'hCD); bus(1'h1, 8'hCD, 8'hAB); bus(1'h1, 8'hC8, 8'h0D);
        pm.pulse_trig();
        rd(8'hCA, 8'hCD); rd(8'hCB, 8'hAB);
        rd(8'hC8, 8'h4D);
        chk("timer_irq", 8'h01, {7'h0, irq});
        bus(1'h1, 8'hC8, 8'h08); tick(3);
        rd(8'hCC, 8'hCD);
        chk("timer_irq", 8'h00, {7'h0, irq});
        bus(1'h1, 8'hC8, 8'h05); pm.pulse_trig();
        rd(8'hC8, 8'h05); rd(8'hCA, 8'hCD);
        bus(1'h1, 8'hCC, 8'h00); bus(1'h1, 8'hCD, 8'h00); bus(1'h1, 8'hC8, 8'h06);
        repeat (3) pm.pulse_cnt();
        rd(8'hCC, 8'h03);
        // down count with the trigger pin low: match, then wrap to FFFF
        bus(1'h1, 8'hC8, 8'h00); bus(1'h1, 8'hC9, 8'h01); pm.set_trig(1'h0);
        bus(1'h1, 8'hCA, 8'h10); bus(1'h1, 8'hCB, 8'h00); bus(1'h1, 8'hCC, 8'h11);
        bus(1'h1, 8'hCD, 8'h00); bus(1'h1, 8'hC8, 8'h04); tick(2);
        rd(8'hCC, 8'hFF); rd(8'hCD, 8'hFF);
        rd(8'hC8, 8'hC4);
        pm.set_trig(1'h1);
        bus(1'h1, 8'hC8, 8'h00); bus(1'h1, 8'hC9, 8'h00); bus(1'h1, 8'hCA, 8'hFE);
        bus(1'h1, 8'hCB, 8'hFF); bus(1'h1, 8'hCC, 8'hFE); bus(1'h1, 8'hCD, 8'hFF);
        bus(1'h1, 8'hC8, 8'h34);
        repeat (4) @(posedge clk);
        @(negedge clk) n0 = pm.baud_cnt;
        repeat (40) @(negedge clk);
        chk("baud pulses", 8'h0A, 8'(pm.baud_cnt - n0));
        chk("baud selects", 8'h03, {6'h0, rx_sel, tx_sel});
        rd(8'hC8, 8'h34);
        // a software write of one to the external flag must raise the request
        bus(1'h1, 8'hC8, 8'h40);
        repeat (2) @(negedge clk);
        chk("timer_irq", 8'h01, {7'h0, irq});
        bus(1'h1, 8'hC8, 8'h04); bus(1'h1, 8'hC9, 8'h02);
        @(negedge clk) chk("counter_pin_oe", 8'h01, {7'h0, pin_oe});
        // reload FFFE at two clocks per step gives one rollover in every 4 clocks
        n0 = pin_out;
        repeat (4) @(negedge clk);
        chk("counter_pin_out", {7'h0, ~n0[0]}, {7'h0, pin_out});
        chk("timer_irq", 8'h00, {7'h0, irq});
        bus(1'h1, 8'hC9, 8'h00);
        @(negedge clk) chk("counter_pin_oe", 8'h00, {7'h0, pin_oe});
        // reset in mid-run must bring control, mode and count high back to their reset values
        @(posedge clk) rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        rd(8'hC8, 8'h00); rd(8'hC9, 8'hFC); rd(8'hCD, 8'h00);
        chk("timer_irq", 8'h00, {7'h0, irq});
        stop_test();
    end
endmodule : atc_timer_tb_top
